// *** drm_pkg.sv ***
// package: constants and types shared by both ends of the dram refresh link
package drm_pkg;
  // refresh mode line codes {high, low}
  localparam logic [1:0] MODE_HOT = 2'h0;
  localparam logic [1:0] MODE_WARM = 2'h1;
  localparam logic [1:0] MODE_COOL = 2'h3;
  // temperature thresholds in degrees c
  localparam int TEMP_HOT_C = 45;
  localparam int TEMP_WARM_C = 25;
  // cool mode write enable period
  localparam int CLK_PERIOD_NS = 50;
  localparam int COOL_WE_US = 305;
  localparam int COOL_WE_CYC = (COOL_WE_US * 1000) / CLK_PERIOD_NS;
  // access phase lengths in cycles
  localparam int ROW_CYC = 2;
  localparam int COL_CYC = 2;
  localparam int REF_CYC = 2;
  // reset values and widths
  localparam logic [1:0] MODE_RST = MODE_HOT;
  localparam int ADDR_W = 16;
  localparam int HALF_W = 8;
  localparam int RADDR_W = 7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ROW = 3'h1,
    ST_COL = 3'h2,
    ST_CPU_REF = 3'h3,
    ST_BG_REF = 3'h4
  } drm_state_t;
endpackage : drm_pkg

// *** drm_link_if.sv ***
// interface: controller to memory chips and mode lines from sub-processor
`timescale 1ns/1ns
interface drm_link_if;
  logic [1:0] refresh_mode;
  logic refresh_mode_high_bit;
  logic refresh_mode_low_bit;
  logic [7:0] mem_addr;
  logic mem_din;
  logic mem_dout;
  logic mem_we_n;
  logic mem_ras_n;
  logic mem_cas_n;
  logic refresh_strobe_n;
  assign refresh_mode_high_bit = refresh_mode[1];
  assign refresh_mode_low_bit = refresh_mode[0];

  modport ctrl (
    input refresh_mode_high_bit,
    input refresh_mode_low_bit,
    output mem_addr,
    output mem_din,
    input mem_dout,
    output mem_we_n,
    output mem_ras_n,
    output mem_cas_n,
    output refresh_strobe_n
  );
  modport subcpu (
    output refresh_mode,
    input refresh_mode_high_bit,
    input refresh_mode_low_bit
  );
endinterface : drm_link_if

// *** drm_ctrl.sv ***
// dram controller: address multiplexing, strobes, cpu and background refresh
`timescale 1ns/1ns
//------------------------------------------------------------
// overview
//------------------------------------------------------------
// Overview of operation
// [RULE1] eight address lines, data pair, four strobes
// [RULE2] address halves presented one after other
// [RULE3] row half with row strobe, then column
// [RULE4] cpu access beats background refresh
// [RULE5] sub-processor steers via two mode lines
// [RULE6] exactly one of three modes, automatic
// [RULE7] sub-processor classifies temperature in three ranges
// [RULE8] sub-processor drives mode levels on ports
// [RULE9] mode lines make refresh cas and we; here only in background refresh, cpu refresh keeps cas and we high
// [RULE10] 00 hot, 01 warm, 11 cool timed
// [RULE11] cpu refresh after fetch becomes refresh
// [RULE12] mode lines also reach external unit
module drm_ctrl
  import drm_pkg::*;
#(
  parameter int COOL_WE_CYCLES = COOL_WE_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // main cpu side
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic memory_request_n,
  input wire logic cpu_refresh_request_in,
  input wire logic opcode_fetch_cycle,
  input wire logic cpu_wr,
  input wire logic cpu_wdata,
  output logic cpu_rdata_ff,
  output logic cpu_done_ff,
  // memory and mode lines
  drm_link_if.ctrl link
);
  initial begin
    // the cool period counter is 20 bits wide
    if (COOL_WE_CYCLES < 1 || COOL_WE_CYCLES > 20'hfffff) begin
      $error("cool period must be 1 to 1048575 cycles");
    end
  end

  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  logic [1:0] mode_s1_ff, mode_s2_ff;
  logic [1:0] dout_s_ff;
  // mode lines come from another chip, so synchronise first
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_s1_ff <= MODE_RST;
      mode_s2_ff <= MODE_RST;
      dout_s_ff <= 2'h0;
    end else begin
      mode_s1_ff <= {link.refresh_mode_high_bit, link.refresh_mode_low_bit}; // see [RULE5]
      mode_s2_ff <= mode_s1_ff;
      dout_s_ff <= {dout_s_ff[0], link.mem_dout};
    end
  end

  //------------------------------------------------------------
  // access sequencer
  //------------------------------------------------------------
  drm_state_t state_ff, nxt_state;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [HALF_W-1:0] addr_ff, nxt_addr;
  logic [ADDR_W-1:0] lat_ff, nxt_lat;
  logic ras_n_ff, nxt_ras_n;
  logic cas_n_ff, nxt_cas_n;
  logic we_n_ff, nxt_we_n;
  logic rf_n_ff, nxt_rf_n;
  logic din_ff, nxt_din;
  logic wr_ff, nxt_wr;
  logic rdata_ff, nxt_rdata;
  logic done_ff, nxt_done;
  logic [19:0] cool_cnt_ff, nxt_cool_cnt;
  logic cool_we_ff, nxt_cool_we;
  logic cpu_req, cpu_ref;

  // strobe levels for background refresh from the mode code
  function automatic logic [1:0] bg_cas_we(input logic [1:0] m, input logic cool_we);
    logic [1:0] r;
    r = 2'h3;
    case (m)
      MODE_HOT: r = 2'h3; // see [RULE10]
      MODE_WARM: r = 2'h2; // see [RULE10]
      MODE_COOL: r = {1'b0, cool_we}; // see [RULE10]
      // 10 is undefined; treat as hot so one mode always applies
      default: r = 2'h3; // see [RULE6]
    endcase
    return r;
  endfunction : bg_cas_we

  // refresh cycles only count while the fetch cycle is flagged
  assign cpu_ref = !memory_request_n && cpu_refresh_request_in && opcode_fetch_cycle; // see [RULE11]
  assign cpu_req = !memory_request_n && !cpu_refresh_request_in;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_addr = addr_ff;
    nxt_lat = lat_ff;
    nxt_ras_n = ras_n_ff;
    nxt_cas_n = cas_n_ff;
    nxt_we_n = we_n_ff;
    nxt_rf_n = rf_n_ff;
    nxt_din = din_ff;
    nxt_wr = wr_ff;
    nxt_rdata = rdata_ff;
    nxt_done = 1'b0;
    // cool mode write enable toggles every period
    nxt_cool_cnt = cool_cnt_ff + 20'h1;
    nxt_cool_we = cool_we_ff;
    if (cool_cnt_ff >= 20'(COOL_WE_CYCLES - 1)) begin
      nxt_cool_cnt = 20'h0;
      nxt_cool_we = !cool_we_ff; // see [RULE10]
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_ras_n = 1'b1;
        nxt_cas_n = 1'b1;
        nxt_we_n = 1'b1;
        nxt_rf_n = 1'b1;
        nxt_cnt = 3'h0;
        if (done_ff) begin
          // cpu still holds the finished request here; taking it would repeat the access
          nxt_state = ST_IDLE;
        end else if (cpu_req) begin // see [RULE4]
          nxt_state = ST_ROW;
          nxt_lat = cpu_addr;
          nxt_wr = cpu_wr;
          nxt_din = cpu_wdata;
          nxt_addr = cpu_addr[ADDR_W-1:HALF_W]; // see [RULE2]
          nxt_ras_n = 1'b0; // see [RULE3]
        end else if (cpu_ref) begin
          nxt_state = ST_CPU_REF;
          nxt_addr = {1'b0, cpu_addr[RADDR_W-1:0]}; // see [RULE11]
          nxt_rf_n = 1'b0; // see [RULE11]
        end else begin
          nxt_state = ST_BG_REF;
        end
      end
      ST_ROW: begin
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == 3'(ROW_CYC - 1)) begin
          // column half changes a cycle before cas falls
          nxt_addr = lat_ff[HALF_W-1:0]; // see [RULE3]
          nxt_we_n = !wr_ff;
          nxt_state = ST_COL;
          nxt_cnt = 3'h0;
        end
      end
      ST_COL: begin
        nxt_cas_n = 1'b0; // see [RULE3]
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == 3'(COL_CYC)) begin
          nxt_rdata = dout_s_ff[1];
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
          nxt_ras_n = 1'b1;
          nxt_cas_n = 1'b1;
          nxt_we_n = 1'b1;
        end
      end
      ST_CPU_REF: begin
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == 3'(REF_CYC - 1)) begin
          nxt_rf_n = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_BG_REF: begin
        // background refresh holds until the cpu wants the memory
        nxt_rf_n = 1'b0;
        {nxt_cas_n, nxt_we_n} = bg_cas_we(mode_s2_ff, cool_we_ff); // see [RULE9]
        if (cpu_req || cpu_ref) begin // see [RULE4]
          nxt_rf_n = 1'b1;
          nxt_cas_n = 1'b1;
          nxt_we_n = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
      addr_ff <= 8'h00;
      lat_ff <= 16'h0000;
      ras_n_ff <= 1'b1;
      cas_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      rf_n_ff <= 1'b1;
      din_ff <= 1'b0;
      wr_ff <= 1'b0;
      rdata_ff <= 1'b0;
      done_ff <= 1'b0;
      cool_cnt_ff <= 20'h0;
      cool_we_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      addr_ff <= nxt_addr;
      lat_ff <= nxt_lat;
      ras_n_ff <= nxt_ras_n;
      cas_n_ff <= nxt_cas_n;
      we_n_ff <= nxt_we_n;
      rf_n_ff <= nxt_rf_n;
      din_ff <= nxt_din;
      wr_ff <= nxt_wr;
      rdata_ff <= nxt_rdata;
      done_ff <= nxt_done;
      cool_cnt_ff <= nxt_cool_cnt;
      cool_we_ff <= nxt_cool_we;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  assign link.mem_addr = addr_ff; // see [RULE1]
  assign link.mem_din = din_ff;
  assign link.mem_ras_n = ras_n_ff;
  assign link.mem_cas_n = cas_n_ff;
  assign link.mem_we_n = we_n_ff;
  assign link.refresh_strobe_n = rf_n_ff;
  assign cpu_rdata_ff = rdata_ff;
  assign cpu_done_ff = done_ff;
endmodule : drm_ctrl

// *** drm_subcpu.sv ***
// sub-processor end: temperature classification onto the two mode lines
`timescale 1ns/1ns
module drm_subcpu
  import drm_pkg::*;
#(
  parameter int TEMP_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // temperature in degrees c, signed two's complement
  input wire logic signed [TEMP_W-1:0] temp_c,
  output logic [1:0] mode_ff,
  // mode lines, also routed to the optional external unit
  drm_link_if.subcpu link,
  output logic ext_mode_high_ff,
  output logic ext_mode_low_ff
);
  initial begin
    if (TEMP_W < 7) $error("temperature width too small for thresholds");
  end

  logic [1:0] m_ff, nxt_m;
  // below zero is outside the ranges; cool is the safest refresh there
  always_comb begin
    if (temp_c >= TEMP_W'(TEMP_HOT_C)) begin
      nxt_m = MODE_HOT; // see [RULE7]
    end else if (temp_c >= TEMP_W'(TEMP_WARM_C)) begin
      nxt_m = MODE_WARM; // see [RULE7]
    end else begin
      nxt_m = MODE_COOL; // see [RULE7]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      m_ff <= MODE_RST;
    end else begin
      m_ff <= nxt_m;
    end
  end

  assign link.refresh_mode = m_ff; // see [RULE5] see [RULE8]
  assign mode_ff = m_ff;
  assign ext_mode_high_ff = m_ff[1]; // see [RULE12]
  assign ext_mode_low_ff = m_ff[0]; // see [RULE12]
endmodule : drm_subcpu

// *** drm_monitor.sv ***
// checker: strobe, address and refresh mode relations on the dram link
`timescale 1ns/1ns
module drm_monitor
  import drm_pkg::*;
#(
  parameter int COOL_WE_CYCLES = COOL_WE_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // link signals
  input wire logic refresh_mode_high_bit,
  input wire logic refresh_mode_low_bit,
  input wire logic [7:0] mem_addr,
  input wire logic mem_we_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic refresh_strobe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // --------------------------------
  // cool mode write enable age
  // --------------------------------
  logic [1:0] md;
  logic bg;
  logic we_q_ff;
  logic nxt_we_q;
  logic [15:0] age_ff;
  logic [15:0] nxt_age;
  assign md = {refresh_mode_high_bit, refresh_mode_low_bit};
  // strobe low with row idle: only background refresh lasts past two cycles
  assign bg = !refresh_strobe_n && mem_ras_n;
  always_comb begin
    nxt_we_q = mem_we_n;
    nxt_age = age_ff + 16'h1;
    if (!(bg && md == MODE_COOL) || mem_we_n != we_q_ff) begin
      nxt_age = 16'h0;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      we_q_ff <= 1'b1;
      age_ff <= 16'h0;
    end else begin
      we_q_ff <= nxt_we_q;
      age_ff <= nxt_age;
    end
  end
  // --------------------------------
  // assertions
  // --------------------------------
  a_cas_after_row: assert property (
    $fell(mem_cas_n) |-> !mem_ras_n || !refresh_strobe_n)
    else $error("column strobe fell with no row or refresh strobe");
  a_cas_delay: assert property (
    $fell(mem_ras_n) |-> ##3 $fell(mem_cas_n))
    else $error("column strobe not three cycles after row strobe");
  a_row_hold: assert property (
    $fell(mem_ras_n) |=> $stable(mem_addr))
    else $error("row half not held after row strobe");
  // row strobe stays low for row and column phases plus the closing cycle
  a_access_len: assert property (
    $fell(mem_ras_n) |-> !mem_ras_n [*5] ##1 mem_ras_n)
    else $error("row strobe length wrong");
  a_refresh_excl: assert property (
    !(!mem_ras_n && !refresh_strobe_n))
    else $error("refresh strobe during cpu access");
  a_hot_lines: assert property (
    (md == MODE_HOT && bg) [*5] |-> mem_cas_n && mem_we_n)
    else $error("hot mode strobes wrong");
  a_warm_lines: assert property (
    (md == MODE_WARM && bg) [*5] |-> mem_cas_n && !mem_we_n)
    else $error("warm mode strobes wrong");
  a_cool_cas: assert property (
    (md == MODE_COOL && bg) [*5] |-> !mem_cas_n)
    else $error("cool mode column strobe not low");
  a_cool_period: assert property (
    age_ff < COOL_WE_CYCLES + 2)
    else $error("cool mode write enable stuck");
endmodule : drm_monitor

// *** tb.sv ***
// testbench: both link ends driven from cpu and temperature sides
`timescale 1ns/1ns
module tb;
  import drm_pkg::*;
  localparam int COOL_N = 8;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] cpu_addr = 16'h0;
  logic memory_request_n = 1'b1;
  logic cpu_refresh_request_in = 1'b0;
  logic opcode_fetch_cycle = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_wdata = 1'b0;
  logic cpu_rdata_ff;
  logic cpu_done_ff;
  logic signed [7:0] temp_c = 8'sh3c;
  logic [1:0] mode_ff;
  logic ext_hi;
  logic ext_lo;
  logic signed [7:0] temps [6] = '{8'sh3c, 8'sh2d, 8'sh2c, 8'sh19, 8'sh18, 8'shfb};
  logic [1:0] modes [6] = '{MODE_HOT, MODE_HOT, MODE_WARM, MODE_WARM, MODE_COOL, MODE_COOL};
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  drm_link_if lnk();
  drm_ctrl #(.COOL_WE_CYCLES(COOL_N)) drm_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst),
    .cpu_addr(cpu_addr), .memory_request_n(memory_request_n),
    .cpu_refresh_request_in(cpu_refresh_request_in), .opcode_fetch_cycle(opcode_fetch_cycle),
    .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata_ff(cpu_rdata_ff),
    .cpu_done_ff(cpu_done_ff), .link(lnk));
  drm_subcpu drm_subcpu_inst (.clk_sys(clk_sys), .nrst(nrst), .temp_c(temp_c),
    .mode_ff(mode_ff), .link(lnk), .ext_mode_high_ff(ext_hi), .ext_mode_low_ff(ext_lo));
  drm_monitor #(.COOL_WE_CYCLES(COOL_N)) drm_monitor_inst (.clk_sys(clk_sys), .nrst(nrst),
    .refresh_mode_high_bit(lnk.refresh_mode_high_bit),
    .refresh_mode_low_bit(lnk.refresh_mode_low_bit), .mem_addr(lnk.mem_addr),
    .mem_we_n(lnk.mem_we_n), .mem_ras_n(lnk.mem_ras_n), .mem_cas_n(lnk.mem_cas_n),
    .refresh_strobe_n(lnk.refresh_strobe_n));
  always #25 clk_sys = ~clk_sys;
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  task automatic rst_chk();
    chk({lnk.mem_ras_n, lnk.mem_cas_n, lnk.refresh_strobe_n, lnk.mem_we_n, cpu_done_ff,
      1'b0, mode_ff}, 8'hf0, "reset");
    chk(lnk.mem_addr, 8'h0, "reset addr");
  endtask : rst_chk
  // fixed walk: request may wait out one background edge, then row at +1
  task automatic access(input logic [15:0] a, input logic wr, input logic d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_wr <= wr;
    cpu_wdata <= d;
    lnk.mem_dout <= d;
    memory_request_n <= 1'b0;
    #1;
    while (lnk.mem_ras_n !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(lnk.mem_addr, a[15:8], "row half");
    repeat (2) @(posedge clk_sys);
    #1;
    chk(lnk.mem_addr, a[7:0], "column half");
    chk({7'h0, lnk.mem_we_n}, {7'h0, !wr}, "write enable");
    @(posedge clk_sys);
    #1;
    chk({7'h0, lnk.mem_cas_n}, 8'h0, "column strobe");
    if (wr) chk({7'h0, lnk.mem_din}, {7'h0, d}, "data in");
    // done stands for one cycle, two edges after the column strobe falls
    repeat (2) @(posedge clk_sys);
    #1;
    chk({7'h0, cpu_done_ff}, 8'h1, "done");
    chk({7'h0, lnk.mem_ras_n}, 8'h1, "row strobe end");
    if (!wr) chk({7'h0, cpu_rdata_ff}, {7'h0, d}, "read data");
    @(posedge clk_sys);
    memory_request_n <= 1'b1;
    #1;
    chk({7'h0, cpu_done_ff}, 8'h0, "done one cycle");
  endtask : access
  task automatic cpu_ref(input logic [15:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_refresh_request_in <= 1'b1;
    opcode_fetch_cycle <= 1'b1;
    memory_request_n <= 1'b0;
    #1;
    while (!(lnk.refresh_strobe_n === 1'b0 && lnk.mem_addr === {1'b0, a[6:0]}) && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    memory_request_n <= 1'b1;
    cpu_refresh_request_in <= 1'b0;
    opcode_fetch_cycle <= 1'b0;
    #1;
    chk({lnk.refresh_strobe_n, lnk.mem_addr[6:0]}, {1'b0, a[6:0]}, "cpu refresh");
  endtask : cpu_ref
  task automatic mode_chk(input logic signed [7:0] t, input logic [1:0] m);
    int n;
    logic w;
    n = 0;
    @(posedge clk_sys);
    temp_c <= t;
    repeat (10) @(posedge clk_sys);
    #1;
    w = lnk.mem_we_n;
    chk({6'h0, mode_ff}, {6'h0, m}, "mode");
    chk({6'h0, lnk.refresh_mode_high_bit, lnk.refresh_mode_low_bit},
      {6'h0, m}, "lines");
    chk({6'h0, ext_hi, ext_lo}, {6'h0, m}, "external lines");
    chk({7'h0, lnk.mem_cas_n}, {7'h0, m != MODE_COOL}, "refresh cas");
    repeat (20) begin
      @(posedge clk_sys);
      #1;
      if (lnk.mem_we_n !== w) n++;
      w = lnk.mem_we_n;
    end
    // cool toggles with half period COOL_N, other modes hold we level
    if (m == MODE_COOL) chk({7'h0, n >= 2}, 8'h1, "cool we toggles");
    else chk({6'h0, n == 0, w}, {6'h0, 1'b1, m == MODE_HOT}, "refresh we");
  endtask : mode_chk
  // --------------------------------
  // sequence
  // --------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end
  initial begin
    lnk.mem_dout <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_chk();
    @(posedge clk_sys);
    nrst <= 1'b1;
    access(16'ha53c, 1'b0, 1'b1);
    access(16'h0ff0, 1'b1, 1'b0);
    access(16'h3c5a, 1'b0, 1'b0);
    cpu_ref(16'h1adb);
    foreach (temps[i]) mode_chk(temps[i], modes[i]);
    access(16'h7e81, 1'b0, 1'b1);
    @(posedge clk_sys);
    nrst <= 1'b0;
    #1;
    rst_chk();
    @(posedge clk_sys);
    nrst <= 1'b1;
    access(16'hc3a5, 1'b1, 1'b1);
    summarize();
  end
endmodule : tb
